// ---- hdl/ibm_pkg.sv ----
package ibm_pkg;

    // ------------------------------------------------------------------
    // Payload sub-block layout
    // ------------------------------------------------------------------
    localparam int         IBM_MAX_LINES = 6;
    localparam logic [2:0] IBM_LINES_RST = 3'h1;
    localparam logic [2:0] IBM_FAST_FORCE_ABOVE = 3'h4;    // More lines than this force the fast channel.
    localparam logic [6:0] IBM_POS_FAST = 7'h00;           // First single-bit timeslot carries the fast channel.
    // Single-bit and octet timeslot counts indexed by line count (index 0 unused).
    localparam logic [6:0] IBM_Z_SLOTS [0:6] = '{7'h00, 7'h03, 7'h05, 7'h07, 7'h01, 7'h03, 7'h05};
    localparam logic [6:0] IBM_B_SLOTS [0:6] = '{7'h00, 7'h02, 7'h04, 7'h06, 7'h09, 7'h0B, 7'h0D};

    // ------------------------------------------------------------------
    // Operations messages
    // ------------------------------------------------------------------
    localparam logic [7:0] IBM_ID_REQ    = 8'h14;          // Identifier 20.
    localparam logic [7:0] IBM_ID_RESP   = 8'h94;          // Identifier 148.
    localparam logic [3:0] IBM_LINE_PAD  = 4'h0;           // Low nibble of the second octet.
    localparam int         IBM_MSG_BITS  = 24;
    localparam logic [4:0] IBM_SER_LEN   = 5'h19;          // Start bit plus three octets.
    localparam logic [4:0] IBM_DES_LEN   = 5'h18;
    localparam int         IBM_FIFO_DEPTH = 32;

    typedef enum logic [1:0] {
        IBM_IDLE = 2'h0,
        IBM_FAST = 2'h1,
        IBM_BEAR = 2'h2,
        IBM_DSIG = 2'h3
    } ibm_kind_t;

    typedef struct packed {
        ibm_kind_t  kind;
        logic [2:0] line;                                  // Zero-based line index.
        logic       ch;                                    // Bearer B1/B2, or earlier/later signalling bit.
        logic [2:0] bit_i;                                 // Bit of the octet, 0 sent first.
    } ibm_slot_t;

    // Number of bits in one payload sub-block.
    function automatic logic [6:0] ibm_blk_bits(input logic [2:0] nl);
        ibm_blk_bits = IBM_Z_SLOTS[nl] + {IBM_B_SLOTS[nl][3:0], 3'h0};
    endfunction : ibm_blk_bits

    // Decode what a given position of the sub-block carries.
    function automatic ibm_slot_t ibm_slot_of(input logic [6:0] pos, input logic [2:0] nl);
        logic [2:0] zl;
        logic [6:0] q;
        logic [3:0] oct;
        logic [3:0] zi;
        ibm_slot_t  s;
        s   = '{IBM_IDLE, 3'h0, 1'b0, 3'h0};
        zl  = (nl > IBM_FAST_FORCE_ABOVE) ? nl - IBM_FAST_FORCE_ABOVE : ((nl == 3'h4) ? 3'h0 : nl);
        q   = pos - IBM_Z_SLOTS[nl];
        oct = q[6:3];
        zi  = pos[3:0] - 4'h1;
        if (pos < IBM_Z_SLOTS[nl]) begin
            if (pos == IBM_POS_FAST) begin
                s.kind = IBM_FAST;
            end else if ({1'b0, zi[3:1]} < {1'b0, zl}) begin
                s = '{IBM_DSIG, zi[3:1], zi[0], 3'h0};
            end
        end else if (nl < IBM_FAST_FORCE_ABOVE) begin
            if (oct < {nl, 1'b0}) begin
                s = '{IBM_BEAR, oct[3:1], oct[0], q[2:0]};
            end
        end else if (oct == 4'h0) begin
            s = '{IBM_DSIG, zl + {1'b0, q[2:1]}, q[0], 3'h0};
        end else if (oct <= {nl, 1'b0}) begin
            s = '{IBM_BEAR, 3'((oct - 4'h1) >> 1), ~oct[0], q[2:0]};
        end
        ibm_slot_of = s;
    endfunction : ibm_slot_of

    // Build a three-octet request or response.
    function automatic logic [23:0] ibm_fmt_msg(input logic resp, input logic [2:0] line, input logic [7:0] code);
        ibm_fmt_msg = {resp ? IBM_ID_RESP : IBM_ID_REQ, 1'b0, line - 3'h1, IBM_LINE_PAD, code};
    endfunction : ibm_fmt_msg

    // Clamp an out-of-range line count to one line.
    function automatic logic [2:0] ibm_clamp(input logic [2:0] nl);
        ibm_clamp = (nl == 3'h0 || nl > 3'h6) ? IBM_LINES_RST : nl;
    endfunction : ibm_clamp

endpackage : ibm_pkg

// ---- hdl/ibm_link_if.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Serial payload link between the two units
// ----------------------------------------------------------------------
interface ibm_link_if;
    logic dn_bit;        // Payload bit toward the customer-side unit.
    logic dn_blk_start;  // High with the first bit of each sub-block.
    logic up_bit;        // Fast channel bit toward the line-side unit.

    modport line_side (output dn_bit, output dn_blk_start, input up_bit);
    modport cust_side (input dn_bit, input dn_blk_start, output up_bit);
endinterface : ibm_link_if

// ---- hdl/ibm_line_side_unit.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Fast channel only in first single-bit slot.
// - One to six lines carried.
// - Signalling follows its bearer one block later.
// - One line: B1 B2, signalling Z2 Z3.
// - Line 2: B3 B4, signalling Z4 Z5.
// - Line 3: B5 B6, signalling Z6 Z7.
// - Four lines: signalling packed into octet one.
// - Five lines: line 1 in Z slots.
// - Six lines: lines 1-2 in Z slots.
// - Status messages ride operations or fast channel.
// - Either unit may send messages anytime.
// - Operations channel normal; fast above four lines.
// - Fast channel optional for low latency.
// - Request: id 20, line, code.
// - Response: id 148, line, code.
// - Line number is index minus one.
// - Single-bit slots precede octet slots.
// - Signalling split over two bit positions.

// ----------------------------------------------------------------------
// Synchronous FIFO
// ----------------------------------------------------------------------
module ibm_fifo #(
    parameter int W = 24,
    parameter int D = 32
) (
    input  wire logic         clock,      // System clock.
    input  wire logic         arst_n,     // Asynchronous reset, active low.
    input  wire logic         in_valid,   // Write request.
    output logic              in_ready,   // Space available.
    input  wire logic [W-1:0] in_data,    // Write data.
    output logic              out_valid,  // Data available.
    input  wire logic         out_ready,  // Read accept.
    output logic [W-1:0]      out_data    // Head word.
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [0:D-1];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0]   cnt_ff;
    logic          push;
    logic          pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (cnt_ff != (AW+1)'(D));
    assign out_valid = (cnt_ff != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rp_ff];

    // Storage has no reset so it maps onto plain memory.
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp_ff] <= in_data;
        end
    end

    // Pointers and count.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ibm_fifo

// ----------------------------------------------------------------------
// Message engine: formatting, queueing, fast channel serial in and out
// ----------------------------------------------------------------------
module ibm_msg_engine (
    input  wire logic        clock,        // System clock.
    input  wire logic        arst_n,       // Asynchronous reset, active low.
    input  wire logic        fast_on,      // Fast channel in use.
    input  wire logic        tick,         // Fast channel slot passes this cycle.
    input  wire logic        rx_bit,       // Received fast channel bit.
    output logic             tx_bit,       // Fast channel bit to send.
    input  wire logic        msg_valid,    // Message request.
    output logic             msg_ready,    // Message accepted.
    input  wire logic        msg_resp,     // High for a response.
    input  wire logic [2:0]  msg_line,     // Line 1 to 6.
    input  wire logic [7:0]  msg_code,     // Message code.
    output logic             eoc_valid,    // Message for the operations channel.
    input  wire logic        eoc_ready,    // Operations channel accepts.
    output logic [23:0]      eoc_data,     // Formatted message.
    output logic             rx_valid,     // Fast channel message received, pulse.
    output logic [23:0]      rx_data       // Received message.
);
    logic [23:0] q_data;
    logic        q_valid;
    logic        q_pop;
    logic        load;
    logic [24:0] sh_ff;
    logic [4:0]  cnt_ff;
    logic [23:0] rsh_ff;
    logic [4:0]  rcnt_ff;
    logic        rdone_ff;

    // Messages queue here so that a slow channel back-pressures the user.
    ibm_fifo #(.W(ibm_pkg::IBM_MSG_BITS), .D(ibm_pkg::IBM_FIFO_DEPTH)) u_fifo (
        .clock     (clock),
        .arst_n    (arst_n),
        .in_valid  (msg_valid),
        .in_ready  (msg_ready),
        .in_data   (ibm_pkg::ibm_fmt_msg(msg_resp, msg_line, msg_code)),
        .out_valid (q_valid),
        .out_ready (q_pop),
        .out_data  (q_data)
    );

    // Without the fast channel the queue drains to the operations channel.
    assign eoc_valid = q_valid && !fast_on;
    assign eoc_data  = q_data;
    assign load      = q_valid && fast_on && (cnt_ff == 5'h00) && !tick;
    assign q_pop     = load || (eoc_valid && eoc_ready);
    assign tx_bit    = (cnt_ff != 5'h00) ? sh_ff[24] : 1'b1;
    assign rx_valid  = rdone_ff;
    assign rx_data   = rsh_ff;

    // Serialiser: idle ones, a zero start bit, then 24 bits MSB first.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sh_ff  <= '0;
            cnt_ff <= '0;
        end else if (load) begin
            sh_ff  <= {1'b0, q_data};
            cnt_ff <= ibm_pkg::IBM_SER_LEN;
        end else if (tick && cnt_ff != 5'h00) begin
            sh_ff  <= {sh_ff[23:0], 1'b0};
            cnt_ff <= cnt_ff - 5'h01;
        end
    end

    // Deserialiser: a zero while idle starts a message.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rsh_ff   <= '0;
            rcnt_ff  <= '0;
            rdone_ff <= 1'b0;
        end else begin
            rdone_ff <= tick && (rcnt_ff == 5'h01);
            if (tick) begin
                if (rcnt_ff == 5'h00) begin
                    if (!rx_bit) begin
                        rcnt_ff <= ibm_pkg::IBM_DES_LEN;
                    end
                end else begin
                    rsh_ff  <= {rsh_ff[22:0], rx_bit};
                    rcnt_ff <= rcnt_ff - 5'h01;
                end
            end
        end
    end
endmodule : ibm_msg_engine

// ----------------------------------------------------------------------
// Line-side unit: maps bearer and signalling into sub-blocks
// ----------------------------------------------------------------------
module ibm_line_side_unit (
    input  wire logic              clock,      // System clock, 20 MHz.
    input  wire logic              arst_n,     // Asynchronous reset, active low.
    ibm_link_if.line_side          link,       // Serial link to the far unit.
    input  wire logic [2:0]        num_lines,  // Lines carried, 1 to 6.
    input  wire logic              fast_en,    // Request the fast channel.
    input  wire logic [5:0][15:0]  bear_in,    // Per line {B1, B2} octets.
    input  wire logic [5:0][1:0]   dsig_in,    // Per line signalling bits, [0] earlier.
    output logic                   blk_take,   // Inputs sampled at this edge.
    output logic                   fast_act,   // Fast channel active.
    input  wire logic              msg_valid,  // Message request.
    output logic                   msg_ready,  // Message accepted.
    input  wire logic              msg_resp,   // High for a response.
    input  wire logic [2:0]        msg_line,   // Line 1 to 6.
    input  wire logic [7:0]        msg_code,   // Message code.
    output logic                   eoc_valid,  // Message for operations channel.
    input  wire logic              eoc_ready,  // Operations channel accepts.
    output logic [23:0]            eoc_data,   // Formatted message.
    output logic                   rx_valid,   // Message received, pulse.
    output logic [23:0]            rx_data     // Received message.
);
    logic [6:0]         pos_ff;
    logic [2:0]         lines_ff;
    logic               fast_ff;
    logic [5:0][15:0]   bear_ff;
    logic [5:0][1:0]    dpend_ff;
    logic [5:0][1:0]    dtx_ff;
    logic               bit_ff;
    logic               start_ff;
    logic               tx_bit;
    logic               tick;
    logic [2:0]         nxt_lines;
    ibm_pkg::ibm_slot_t slot;
    logic               nxt_bit;

    assign blk_take  = (pos_ff == ibm_pkg::ibm_blk_bits(lines_ff) - 7'h01);
    assign nxt_lines = ibm_pkg::ibm_clamp(num_lines);
    assign tick      = (pos_ff == ibm_pkg::IBM_POS_FAST) && fast_ff;
    assign fast_act  = fast_ff;
    assign slot      = ibm_pkg::ibm_slot_of(pos_ff, lines_ff);
    assign link.dn_bit       = bit_ff;
    assign link.dn_blk_start = start_ff;

    // Position counter; the layout changes only on a block boundary.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pos_ff   <= '0;
            lines_ff <= ibm_pkg::IBM_LINES_RST;
            fast_ff  <= 1'b0;
        end else if (blk_take) begin
            pos_ff   <= '0;
            lines_ff <= nxt_lines;
            fast_ff  <= fast_en || (nxt_lines > ibm_pkg::IBM_FAST_FORCE_ABOVE);
        end else begin
            pos_ff <= pos_ff + 7'h01;
        end
    end

    // Signalling waits one block so it follows its own bearer octets.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bear_ff  <= '0;
            dpend_ff <= '0;
            dtx_ff   <= '0;
        end else if (blk_take) begin
            bear_ff  <= bear_in;
            dpend_ff <= dsig_in;
            dtx_ff   <= dpend_ff;
        end
    end

    // Pick the bit for this position; unused positions send ones.
    always_comb begin
        nxt_bit = 1'b1;
        case (slot.kind)
            ibm_pkg::IBM_FAST: nxt_bit = fast_ff ? tx_bit : 1'b1;
            ibm_pkg::IBM_BEAR: nxt_bit = bear_ff[slot.line][{~slot.ch, ~slot.bit_i}];
            ibm_pkg::IBM_DSIG: nxt_bit = dtx_ff[slot.line][slot.ch];
            default:           nxt_bit = 1'b1;
        endcase
    end

    // Link outputs leave from flip-flops.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bit_ff   <= 1'b1;
            start_ff <= 1'b0;
        end else begin
            bit_ff   <= nxt_bit;
            start_ff <= (pos_ff == 7'h00);
        end
    end

    ibm_msg_engine u_msg (
        .clock     (clock),
        .arst_n    (arst_n),
        .fast_on   (fast_ff),
        .tick      (tick),
        .rx_bit    (link.up_bit),
        .tx_bit    (tx_bit),
        .msg_valid (msg_valid),
        .msg_ready (msg_ready),
        .msg_resp  (msg_resp),
        .msg_line  (msg_line),
        .msg_code  (msg_code),
        .eoc_valid (eoc_valid),
        .eoc_ready (eoc_ready),
        .eoc_data  (eoc_data),
        .rx_valid  (rx_valid),
        .rx_data   (rx_data)
    );
endmodule : ibm_line_side_unit

// ---- hdl/ibm_customer_side_unit.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Customer-side unit: recovers bearer and signalling from sub-blocks
// ----------------------------------------------------------------------
module ibm_customer_side_unit (
    input  wire logic              clock,      // System clock, 20 MHz.
    input  wire logic              arst_n,     // Asynchronous reset, active low.
    ibm_link_if.cust_side          link,       // Serial link to the far unit.
    input  wire logic [2:0]        num_lines,  // Lines carried, must match far end.
    input  wire logic              fast_en,    // Request the fast channel.
    output logic [5:0][15:0]       bear_out,   // Per line {B1, B2} octets.
    output logic [5:0][1:0]        dsig_out,   // Signalling paired with bear_out.
    output logic                   blk_valid,  // New block on outputs, pulse.
    input  wire logic              msg_valid,  // Message request.
    output logic                   msg_ready,  // Message accepted.
    input  wire logic              msg_resp,   // High for a response.
    input  wire logic [2:0]        msg_line,   // Line 1 to 6.
    input  wire logic [7:0]        msg_code,   // Message code.
    output logic                   eoc_valid,  // Message for operations channel.
    input  wire logic              eoc_ready,  // Operations channel accepts.
    output logic [23:0]            eoc_data,   // Formatted message.
    output logic                   rx_valid,   // Message received, pulse.
    output logic [23:0]            rx_data     // Received message.
);
    logic [6:0]         rpos_ff;
    logic [6:0]         cur_pos;
    logic [2:0]         lines_ff;
    logic [2:0]         cur_lines;
    logic               fast_ff;
    logic               cur_fast;
    logic [5:0][15:0]   bcol_ff;
    logic [5:0][15:0]   bhold_ff;
    logic [5:0][1:0]    dcol_ff;
    logic [5:0][15:0]   bout_ff;
    logic [5:0][1:0]    dout_ff;
    logic               bvld_ff;
    logic               up_ff;
    logic               tx_bit;
    logic               tick;
    ibm_pkg::ibm_slot_t slot;

    // The layout is taken up on the first bit of a block, as at the sender.
    assign cur_pos   = link.dn_blk_start ? 7'h00 : rpos_ff + 7'h01;
    assign cur_lines = link.dn_blk_start ? ibm_pkg::ibm_clamp(num_lines) : lines_ff;
    assign cur_fast  = link.dn_blk_start ? (fast_en || cur_lines > ibm_pkg::IBM_FAST_FORCE_ABOVE) : fast_ff;
    assign slot      = ibm_pkg::ibm_slot_of(cur_pos, cur_lines);
    assign tick      = (slot.kind == ibm_pkg::IBM_FAST) && cur_fast;
    assign bear_out  = bout_ff;
    assign dsig_out  = dout_ff;
    assign blk_valid = bvld_ff;
    assign link.up_bit = up_ff;

    // Position tracking follows the block start marker.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rpos_ff  <= '0;
            lines_ff <= ibm_pkg::IBM_LINES_RST;
            fast_ff  <= 1'b0;
        end else begin
            rpos_ff  <= cur_pos;
            lines_ff <= cur_lines;
            fast_ff  <= cur_fast;
        end
    end

    // Collect bits; at a block start, bearer octets of the block before last
    // are released with the signalling that just arrived for them.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bcol_ff  <= '0;
            bhold_ff <= '0;
            dcol_ff  <= '0;
            bout_ff  <= '0;
            dout_ff  <= '0;
            bvld_ff  <= 1'b0;
        end else begin
            bvld_ff <= link.dn_blk_start;
            if (link.dn_blk_start) begin
                bout_ff  <= bhold_ff;
                dout_ff  <= dcol_ff;
                bhold_ff <= bcol_ff;
            end
            if (slot.kind == ibm_pkg::IBM_BEAR) begin
                bcol_ff[slot.line][{~slot.ch, ~slot.bit_i}] <= link.dn_bit;
            end
            if (slot.kind == ibm_pkg::IBM_DSIG) begin
                dcol_ff[slot.line][slot.ch] <= link.dn_bit;
            end
        end
    end

    // Upstream fast channel bit is taken only at the fast slot and then held
    // for the whole block. A message loaded just before the slot could
    // otherwise lose its start bit before the far end samples it.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            up_ff <= 1'b1;
        end else if (tick) begin
            up_ff <= tx_bit;
        end
    end

    ibm_msg_engine u_msg (
        .clock     (clock),
        .arst_n    (arst_n),
        .fast_on   (cur_fast),
        .tick      (tick),
        .rx_bit    (link.dn_bit),
        .tx_bit    (tx_bit),
        .msg_valid (msg_valid),
        .msg_ready (msg_ready),
        .msg_resp  (msg_resp),
        .msg_line  (msg_line),
        .msg_code  (msg_code),
        .eoc_valid (eoc_valid),
        .eoc_ready (eoc_ready),
        .eoc_data  (eoc_data),
        .rx_valid  (rx_valid),
        .rx_data   (rx_data)
    );
endmodule : ibm_customer_side_unit

// ---- verif/ibm_link_properties.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Link checker
// ----------------------------------------------------------------------
module ibm_link_properties (
    input wire logic clock,        // System clock.
    input wire logic arst_n,       // Asynchronous reset, active low.
    input wire logic dn_bit,       // Payload bit downstream.
    input wire logic dn_blk_start, // Sub-block start marker.
    input wire logic up_bit        // Fast channel bit upstream.
);
    logic [6:0] cnt_ff;
    logic       seen_ff;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // Cycles since the last start; saturates so that a stalled link stays visible.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff  <= 7'h00;
            seen_ff <= 1'b0;
        end else begin
            cnt_ff  <= dn_blk_start ? 7'h01 : cnt_ff + {6'h00, cnt_ff != 7'h7F};
            seen_ff <= seen_ff | dn_blk_start;
        end
    end
    property p_start_pulse; dn_blk_start |=> !dn_blk_start [*8]; endproperty
    property p_len_legal; dn_blk_start && seen_ff |-> cnt_ff inside {7'h13, 7'h25, 7'h37, 7'h49, 7'h5B, 7'h6D};
    endproperty
    property p_len_max; seen_ff |-> cnt_ff <= 7'h6D; endproperty
    property p_rst_idle; $rose(arst_n) |-> dn_bit && up_bit && !dn_blk_start; endproperty
    property p_rst_start; $rose(arst_n) |-> ##[1:3] dn_blk_start; endproperty
    property p_up_idle; $rose(arst_n) |-> up_bit [*8]; endproperty
    property p_up_hold; $changed(up_bit) |=> $stable(up_bit) [*8]; endproperty
    property p_up_slot; seen_ff && $changed(up_bit) |-> cnt_ff <= 7'h08; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start marker too close");
    a_len_legal: assert property (p_len_legal) else $error("illegal block length");
    a_len_max: assert property (p_len_max) else $error("block start missing");
    a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
    a_rst_start: assert property (p_rst_start) else $error("no block after reset");
    a_up_idle: assert property (p_up_idle) else $error("fast channel not idle");
    a_up_hold: assert property (p_up_hold) else $error("fast bit changed twice in a block");
    a_up_slot: assert property (p_up_slot) else $error("fast bit outside its slot");
    c_six: cover property (dn_blk_start && cnt_ff == 7'h6D);
    c_four: cover property (dn_blk_start && cnt_ff == 7'h49);
    c_msg: cover property ($fell(up_bit));
endmodule : ibm_link_properties

// ---- verif/isdn_ba_payload_mapper_test.sv ----
`timescale 1ns/1ps
module isdn_ba_payload_mapper_test;
    logic             clock = 0, arst_n = 0, fast_en = 0, resp = 0, e_rdy = 0, fa;
    logic [1:0]       mv = 0, mr, ev, rv, bv;
    logic [2:0]       nl = 1, mline = 1;
    logic [7:0]       code = 0;
    logic [5:0][15:0] bi = '0, bo;
    logic [5:0][1:0]  di = '0, dso;
    logic [1:0][23:0] ed, rd;
    int               mismatches = 0, n_checks = 0, cycles = 0;
    ibm_link_if ibm_link_if_inst ();
    ibm_line_side_unit ibm_line_side_unit_inst (.clock(clock), .arst_n(arst_n), .link(ibm_link_if_inst), .num_lines(nl),
        .fast_en(fast_en), .bear_in(bi), .dsig_in(di), .blk_take(bv[0]), .fast_act(fa), .msg_valid(mv[0]),
        .msg_ready(mr[0]), .msg_resp(resp), .msg_line(mline), .msg_code(code), .eoc_valid(ev[0]), .eoc_ready(e_rdy),
        .eoc_data(ed[0]), .rx_valid(rv[0]), .rx_data(rd[0]));
    ibm_customer_side_unit ibm_customer_side_unit_inst (.clock(clock), .arst_n(arst_n), .link(ibm_link_if_inst),
        .num_lines(nl), .fast_en(fast_en), .bear_out(bo), .dsig_out(dso), .blk_valid(bv[1]), .msg_valid(mv[1]),
        .msg_ready(mr[1]), .msg_resp(resp), .msg_line(mline), .msg_code(code), .eoc_valid(ev[1]), .eoc_ready(e_rdy),
        .eoc_data(ed[1]), .rx_valid(rv[1]), .rx_data(rd[1]));
    ibm_link_properties ibm_link_properties_inst (.clock(clock), .arst_n(arst_n), .dn_bit(ibm_link_if_inst.dn_bit),
        .dn_blk_start(ibm_link_if_inst.dn_blk_start), .up_bit(ibm_link_if_inst.up_bit));
    // Clock and a hang guard; the ceiling is well above the expected run.
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Captures two blocks of the wire; signalling is changed after the first bit, so it must lag one block.
    task automatic t_map(input logic [2:0] n);
        logic [255:0] blk;
        logic [7:0]   oct;
        logic [1:0]   old;
        int           ks, off;
        nl = n;
        fast_en = 1;
        for (int k = 0; k < 6; k++) bi[k] = {4'hA, 4'(k), 4'h5, ~4'(k)};
        for (int k = 0; k < 6; k++) di[k] = 2'(k) ^ 2'h2;
        ks = 32'(ibm_pkg::IBM_Z_SLOTS[n]) + 8 * 32'(ibm_pkg::IBM_B_SLOTS[n]);
        off = 32'(ibm_pkg::IBM_Z_SLOTS[n]) + ((n > 3'h3) ? 8 : 0);
        step(4 * ks);
        for (int k = 0; k < 300 && ibm_link_if_inst.dn_blk_start !== 1'b1; k++) step(1);
        old = di[0];
        for (int p = 0; p < 2 * ks; p++) begin
            blk[p] = ibm_link_if_inst.dn_bit;
            if (p == 0) di[0] = ~old;
            if (p < ks) check(bv, {p == 1, p == ks - 2});
            step(1);
        end
        for (int i = 0; i < 8; i++) oct[7 - i] = blk[off + i];
        check(blk[0], 1'b1);
        check(fa, 1'b1);
        check(oct, bi[0][15:8]);
        check({blk[ks + 2], blk[ks + 1]}, old);
        step(3 * ks);
        for (int k = 0; k < 6; k++) if (k < n) check({bo[k], dso[k]}, {bi[k], di[k]});
    endtask : t_map
    // Fills the operations queue until it refuses, drains it, then sends one response upstream.
    task automatic t_msg();
        int cnt = 0;
        nl = 1;
        fast_en = 0;
        mline = 6;
        code = 8'h31;
        step(150);
        check(fa, 1'b0);
        mv[0] = 1;
        repeat (40) begin
            if (mr[0]) cnt++;
            step(1);
        end
        mv[0] = 0;
        check(cnt, 32);
        check(ed[0], {8'h14, 4'h5, 4'h0, 8'h31});
        cnt = 0;
        e_rdy = 1;
        repeat (40) begin
            if (ev[0]) cnt++;
            step(1);
        end
        check(cnt, 32);
        e_rdy = 0;
        {resp, mline, code, mv[1]} = {1'b1, 3'h1, 8'h81, 1'b1};
        step(1);
        mv[1] = 0;
        check(ev[1], 1'b1);
        check(ed[1], {8'h94, 8'h00, 8'h81});
        e_rdy = 1;
        step(1);
        e_rdy = 0;
    endtask : t_msg
    // Both units send a request at once over the fast channel.
    task automatic t_fast();
        logic [1:0] got = 0;
        {fast_en, resp, mline, code, mv} = {1'b1, 1'b0, 3'h3, 8'h12, 2'h3};
        step(1);
        mv = 0;
        repeat (1200) begin
            got = got | rv;
            step(1);
        end
        check(got, 2'h3);
        check(rd[0], {8'h14, 8'h20, 8'h12});
        check(rd[1], {8'h14, 8'h20, 8'h12});
    endtask : t_fast
    initial begin
        step(20);
        arst_n = 1;
        for (int n = 1; n <= 6; n++) t_map(3'(n));
        t_msg();
        t_fast();
        print_verdict();
    end
endmodule : isdn_ba_payload_mapper_test
